// ### rtl/dir_converter.sv
// Purpose: Host serial port to RS-485/RS-422 converter with bus direction control.
// Assumes: Switches are static levels; host and bus lines idle high.
// Notes:   Switches are read once after reset; APB holds control and status.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module dir_converter #(
    parameter bit          LATE_REVISION = 1'b1,
    parameter int unsigned CYC_1200      = conv_pkg::BIT_CYC_1200,
    parameter int unsigned CYC_2400      = conv_pkg::BIT_CYC_2400,
    parameter int unsigned CYC_4800      = conv_pkg::BIT_CYC_4800
) (
    input  wire logic        pclk,                  // System clock, 25 MHz.
    input  wire logic        presetn,               // Asynchronous reset, active low.
    input  wire logic        psel,                  // APB select.
    input  wire logic        penable,               // APB enable.
    input  wire logic        pwrite,                // APB write.
    input  wire logic [11:0] paddr,                 // APB byte address.
    input  wire logic [31:0] pwdata,                // APB write data.
    output logic      [31:0] prdata,                // APB read data.
    output logic             pready,                // APB ready.
    output logic             pslverr,               // APB error for unmapped address.
    input  wire logic [6:0]  rate_select_switches,  // Rate switch bank, one-hot.
    input  wire logic [1:0]  frame_format_switches, // Frame length switches.
    input  wire logic        host_txd,              // Serial data from host.
    input  wire logic        host_rts,              // Host RTS, high requests transmit.
    output logic             host_rxd,              // Serial data to host.
    input  wire logic        bus_data_in,           // Two-wire pair, received level.
    output logic             bus_data_out,          // Two-wire pair, driven level.
    output logic             bus_data_oe,           // Two-wire pair driver enable.
    output logic             tx_pair_out,           // Four-wire transmit pair.
    input  wire logic        rx_pair_in             // Four-wire receive pair.
);
    localparam int PW = conv_pkg::PERIOD_W;

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers for every switch and line input.
    logic [6:0] rate_s;
    logic [1:0] fmt_s;
    logic [3:0] line_s;
    logic [8:0] switch_s;
    logic       host_txd_s;
    logic       host_rts_s;
    logic       bus_in_s;
    logic       rx_pair_s;

    sync_2ff #(.WIDTH(9), .INIT(1'b0)) u_sync_switch (
        .pclk    (pclk),
        .presetn (presetn),
        .async_i ({rate_select_switches, frame_format_switches}),
        .sync_o  (switch_s)
    );

    sync_2ff #(.WIDTH(4), .INIT(1'b1)) u_sync_line (
        .pclk    (pclk),
        .presetn (presetn),
        .async_i ({host_txd, host_rts, bus_data_in, rx_pair_in}),
        .sync_o  (line_s)
    );

    assign {host_txd_s, host_rts_s, bus_in_s, rx_pair_s} = line_s;
    assign {rate_s, fmt_s} = switch_s;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding of the switch banks.
    function automatic logic [2:0] rate_index(input logic [6:0] sw);
        logic [2:0] idx;
        case (sw)
            7'h01:   idx = conv_pkg::IDX_RTS;
            7'h02:   idx = conv_pkg::IDX_1200;
            7'h04:   idx = conv_pkg::IDX_2400;
            7'h08:   idx = conv_pkg::IDX_4800;
            7'h10:   idx = conv_pkg::IDX_9600;
            7'h20:   idx = conv_pkg::IDX_19200;
            7'h40:   idx = conv_pkg::IDX_38400;
            default: idx = conv_pkg::IDX_9600;
        endcase
        return idx;
    endfunction : rate_index

    function automatic logic [PW-1:0] bit_cycles(input logic [2:0] idx);
        logic [PW-1:0] cyc;
        case (idx)
            conv_pkg::IDX_1200:  cyc = LATE_REVISION ? PW'(conv_pkg::BIT_CYC_115200) : PW'(CYC_1200);
            conv_pkg::IDX_2400:  cyc = PW'(CYC_2400);
            conv_pkg::IDX_4800:  cyc = PW'(CYC_4800);
            conv_pkg::IDX_19200: cyc = PW'(conv_pkg::BIT_CYC_19200);
            conv_pkg::IDX_38400: cyc = PW'(conv_pkg::BIT_CYC_38400);
            default:             cyc = PW'(conv_pkg::BIT_CYC_9600);
        endcase
        return cyc;
    endfunction : bit_cycles

    ////////////////////////////////////////////////////////////////////////////
    // Power-up capture of the switches.
    conv_pkg::cfg_s cfg_q;
    logic           cfg_valid_q;
    logic [1:0]     cap_cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cap_cnt_q   <= '0;
            cfg_valid_q <= 1'b0;
            cfg_q       <= conv_pkg::CFG_RESET;
        end
        else if (!cfg_valid_q)
        begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
            if (cap_cnt_q == conv_pkg::CAP_WAIT)
            begin
                cfg_valid_q    <= 1'b1;
                cfg_q.rate_idx <= rate_index(rate_s);
                cfg_q.rts_mode <= (rate_index(rate_s) == conv_pkg::IDX_RTS);
                cfg_q.fmt      <= fmt_s;
            end
        end
    end

    // One period and one frame length serve host and bus alike.
    logic [PW-1:0] bit_cyc;
    logic [3:0]    frame_bits;

    assign bit_cyc    = bit_cycles(cfg_q.rate_idx);
    assign frame_bits = conv_pkg::FRAME_BASE + {2'h0, cfg_q.fmt};

    ////////////////////////////////////////////////////////////////////////////
    // Direction control.
    conv_pkg::dir_e dir_q;
    conv_pkg::dir_e dir_d;
    logic           host_prev_q;
    logic [3:0]     bit_idx_q;
    logic           start_edge;
    logic           tick;
    logic           frame_end;
    logic           four_wire_q;
    logic [15:0]    frames_q;
    assign start_edge = host_prev_q & ~host_txd_s;
    assign frame_end  = (dir_q == conv_pkg::DIR_DRIVE) && tick && (bit_idx_q == frame_bits - 4'h1);
    bit_timer #(.W(PW)) u_bit_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (dir_q == conv_pkg::DIR_RECEIVE),
        .period  (bit_cyc),
        .tick    (tick)
    );

    always_comb
    begin
        dir_d = dir_q;
        if (!cfg_valid_q)
        begin
            dir_d = conv_pkg::DIR_RECEIVE;
        end
        else if (cfg_q.rts_mode)
        begin
            dir_d = host_rts_s ? conv_pkg::DIR_DRIVE : conv_pkg::DIR_RECEIVE;
        end
        else
        begin
            case (dir_q)
                conv_pkg::DIR_RECEIVE:
                begin
                    if (start_edge)
                    begin
                        dir_d = conv_pkg::DIR_DRIVE;
                    end
                end
                conv_pkg::DIR_DRIVE:
                begin
                    if (frame_end)
                    begin
                        dir_d = conv_pkg::DIR_RECEIVE;
                    end
                end
                default: dir_d = conv_pkg::DIR_RECEIVE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_q       <= conv_pkg::DIR_RECEIVE;
            host_prev_q <= 1'b1;
        end
        else
        begin
            dir_q       <= dir_d;
            host_prev_q <= host_txd_s;
        end
    end

    // Bit position inside the frame being forwarded.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_idx_q <= '0;
        end
        else if (dir_q == conv_pkg::DIR_RECEIVE)
        begin
            bit_idx_q <= '0;
        end
        else if (tick)
        begin
            bit_idx_q <= bit_idx_q + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frames_q <= '0;
        end
        else if (frame_end && !cfg_q.rts_mode)
        begin
            frames_q <= frames_q + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line outputs.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_data_out <= 1'b1;
            bus_data_oe  <= 1'b0;
            tx_pair_out  <= 1'b1;
            host_rxd     <= 1'b1;
        end
        else
        begin
            bus_data_out <= host_txd_s;
            bus_data_oe  <= (dir_d == conv_pkg::DIR_DRIVE) && !four_wire_q;
            tx_pair_out  <= host_txd_s;
            if (four_wire_q)
            begin
                host_rxd <= rx_pair_s;
            end
            else
            begin
                // The own driven bits are not echoed back to the host.
                host_rxd <= (dir_d == conv_pkg::DIR_DRIVE) ? 1'b1 : bus_in_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave with one wait state.
    logic        acc_first;
    logic        hit_ctrl;
    logic        hit_status;
    logic        hit_frames;
    logic [31:0] status_word;
    assign acc_first   = psel && penable && !pready;
    assign hit_ctrl    = (paddr == conv_pkg::OFS_CTRL);
    assign hit_status  = (paddr == conv_pkg::OFS_STATUS);
    assign hit_frames  = (paddr == conv_pkg::OFS_FRAMES);
    assign status_word = {20'h0, frame_bits, dir_q == conv_pkg::DIR_DRIVE, cfg_q.fmt,
                          cfg_q.rate_idx, cfg_q.rts_mode, cfg_valid_q};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else if (acc_first)
        begin
            pready  <= 1'b1;
            pslverr <= !(hit_ctrl || hit_status || hit_frames);
            if (pwrite || !(hit_ctrl || hit_status || hit_frames))
            begin
                prdata <= '0;
            end
            else if (hit_ctrl)
            begin
                prdata <= {31'h0, four_wire_q};
            end
            else if (hit_status)
            begin
                prdata <= status_word;
            end
            else
            begin
                prdata <= {16'h0, frames_q};
            end
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            four_wire_q <= conv_pkg::CTRL_RESET;
        end
        else if (psel && penable && pready && pwrite && hit_ctrl)
        begin
            four_wire_q <= pwdata[conv_pkg::CTRL_FOUR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_default_rate: assert property (
        cfg_valid_q && cfg_q.rate_idx == conv_pkg::IDX_9600 |-> bit_cyc == PW'(conv_pkg::BIT_CYC_9600))
        else $error("Default rate does not give the 9600 baud period.");
    a_rate_decode: assert property (
        cfg_valid_q && $rose(cfg_valid_q) && $past(rate_s) == 7'h40 |-> cfg_q.rate_idx == conv_pkg::IDX_38400)
        else $error("Seventh rate position did not select 38400 baud.");
    a_rev_rate: assert property (
        cfg_q.rate_idx == conv_pkg::IDX_1200 |->
        bit_cyc == (LATE_REVISION ? PW'(conv_pkg::BIT_CYC_115200) : PW'(CYC_1200)))
        else $error("Second rate position gives the wrong period for this revision.");
    a_cfg_frozen: assert property (
        cfg_valid_q && $past(cfg_valid_q) |-> $stable(cfg_q) && $stable(bit_cyc))
        else $error("Configuration changed after power-up capture.");
    a_frame_len: assert property (
        $rose(cfg_valid_q) |-> frame_bits == conv_pkg::FRAME_BASE + {2'h0, $past(fmt_s)})
        else $error("Frame length does not follow the format switches.");
    a_default_fmt: assert property (
        cfg_q.fmt == conv_pkg::FMT_DEFAULT |-> frame_bits == conv_pkg::FRAME_DEF)
        else $error("Default format does not give a 10-bit frame.");
    a_rts_follow: assert property (
        cfg_valid_q && cfg_q.rts_mode && !four_wire_q ##1 cfg_valid_q && !four_wire_q |->
        bus_data_oe == $past(host_rts_s))
        else $error("Bus driver does not follow RTS in RTS mode.");
    a_auto_start: assert property (
        cfg_valid_q && !cfg_q.rts_mode && !four_wire_q && dir_q == conv_pkg::DIR_RECEIVE && start_edge
        |=> bus_data_oe ##1 dir_q == conv_pkg::DIR_DRIVE)
        else $error("Start bit from host did not enable the bus driver.");
    a_auto_release: assert property (
        !cfg_q.rts_mode && $fell(dir_q) |->
        $past(tick) && $past(bit_idx_q) == frame_bits - 4'h1)
        else $error("Driver released before the final stop bit ended.");
    a_four_wire: assert property (
        four_wire_q |=> !bus_data_oe)
        else $error("Two-wire driver enabled in four-wire mode.");

endmodule : dir_converter

// ### rtl/conv_pkg.sv
// Purpose: Shared constants and types for the serial direction converter.
// Assumes: A 25 MHz pclk; APB registers are one aligned 32-bit word each.
// Notes:   Bit periods round down to whole clock cycles.
package conv_pkg;

    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned BAUD_1200   = 1200;
    localparam int unsigned BAUD_2400   = 2400;
    localparam int unsigned BAUD_4800   = 4800;
    localparam int unsigned BAUD_9600   = 9600;
    localparam int unsigned BAUD_19200  = 19200;
    localparam int unsigned BAUD_38400  = 38400;
    localparam int unsigned BAUD_115200 = 115200;

    localparam int unsigned BIT_CYC_1200   = CLK_HZ / BAUD_1200;
    localparam int unsigned BIT_CYC_2400   = CLK_HZ / BAUD_2400;
    localparam int unsigned BIT_CYC_4800   = CLK_HZ / BAUD_4800;
    localparam int unsigned BIT_CYC_9600   = CLK_HZ / BAUD_9600;
    localparam int unsigned BIT_CYC_19200  = CLK_HZ / BAUD_19200;
    localparam int unsigned BIT_CYC_38400  = CLK_HZ / BAUD_38400;
    localparam int unsigned BIT_CYC_115200 = CLK_HZ / BAUD_115200;

    localparam int          PERIOD_W   = 16;
    localparam int          RATE_POS_N = 7;

    // Rate index: position of the closed rate switch, counted from zero.
    localparam logic [2:0]  IDX_RTS    = 3'h0;
    localparam logic [2:0]  IDX_1200   = 3'h1;
    localparam logic [2:0]  IDX_2400   = 3'h2;
    localparam logic [2:0]  IDX_4800   = 3'h3;
    localparam logic [2:0]  IDX_9600   = 3'h4;
    localparam logic [2:0]  IDX_19200  = 3'h5;
    localparam logic [2:0]  IDX_38400  = 3'h6;

    localparam logic [1:0]  FMT_DEFAULT = 2'h1;
    localparam logic [3:0]  FRAME_BASE  = 4'h9;
    localparam logic [3:0]  FRAME_DEF   = 4'hA;
    localparam logic [1:0]  CAP_WAIT    = 2'h3;

    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_STATUS  = 12'h004;
    localparam logic [11:0] OFS_FRAMES  = 12'h008;
    localparam int          CTRL_FOUR   = 0;
    localparam logic        CTRL_RESET  = 1'b0;

    typedef struct packed {
        logic       rts_mode;
        logic [2:0] rate_idx;
        logic [1:0] fmt;
    } cfg_s;

    localparam cfg_s CFG_RESET = '{rts_mode: 1'b0, rate_idx: IDX_9600, fmt: FMT_DEFAULT};

    typedef enum logic [0:0] {
        DIR_RECEIVE = 1'b0,
        DIR_DRIVE   = 1'b1
    } dir_e;

endpackage : conv_pkg

// ### rtl/sync_2ff.sv
// Purpose: Two-flop synchroniser for asynchronous levels.
// Assumes: Inputs change slowly compared with pclk.
// Notes:   The first stage is read only by the second.
`timescale 1ns/1ps
module sync_2ff #(
    parameter int         WIDTH = 1,
    parameter logic [0:0] INIT  = 1'b1
) (
    input  wire logic             pclk,    // System clock.
    input  wire logic             presetn, // Asynchronous reset, active low.
    input  wire logic [WIDTH-1:0] async_i, // Asynchronous level in.
    output logic      [WIDTH-1:0] sync_o   // Synchronised level out.
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= {WIDTH{INIT}};
            sync_o <= {WIDTH{INIT}};
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : sync_2ff

// ### rtl/bit_timer.sv
// Purpose: Counts one serial bit period and pulses at its end.
// Assumes: period is at least two cycles and stays stable while running.
// Notes:   restart clears the count so the next tick is a full period away.
`timescale 1ns/1ps
module bit_timer #(
    parameter int W = conv_pkg::PERIOD_W
) (
    input  wire logic         pclk,    // System clock.
    input  wire logic         presetn, // Asynchronous reset, active low.
    input  wire logic         restart, // Start a fresh bit period.
    input  wire logic [W-1:0] period,  // Bit period in clock cycles.
    output logic              tick     // One-cycle pulse at period end.
);

    logic [W-1:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else if (restart)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            // The tick is registered, so it is raised one cycle early to land on the period end.
            cnt_q <= (cnt_q == period - W'(1)) ? '0 : cnt_q + W'(1);
            tick  <= (cnt_q == period - W'(2));
        end
    end

endmodule : bit_timer

// ### tb/serial_peer_model.sv
// Purpose: Host serial port and remote bus node facing the converter.
// Assumes: Lines idle high; every change follows a rising pclk edge.
// Notes:   Frames go out whole: one start bit, data, one stop bit.
`timescale 1ns/1ps
module serial_peer_model (
    input  wire logic pclk,     // System clock.
    output logic      host_txd, // Host transmit line.
    output logic      host_rts, // Host RTS line.
    output logic      node_txd  // Remote node transmit level.
);
    initial
    begin
        host_txd = 1'b1;
        host_rts = 1'b0;
        node_txd = 1'b1;
    end

    // The host side uses the rate and length given by the caller.
    task automatic send_frame(input int nbits, input int cyc, input logic [9:0] data);
        for (int i = 0; i < nbits; i++)
        begin
            host_txd <= (i == 0) ? 1'b0 : (i == nbits - 1) ? 1'b1 : data[i-1];
            repeat (cyc) @(posedge pclk);
        end
    endtask : send_frame

    task automatic set_lines(input logic rts, input logic node);
        host_rts <= rts;
        node_txd <= node;
    endtask : set_lines
endmodule : serial_peer_model

// ### tb/tb_dir_converter.sv
// Purpose: Self-checking bench for the serial direction converter.
// Assumes: The 2400 and 4800 rate positions are shortened to SMALL_CYC cycles a bit.
// Notes:   Each configuration needs a fresh reset to be captured.
`timescale 1ns/1ps
module tb_dir_converter;
    localparam int SMALL_CYC = 20;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [6:0]  rate_sw = 7'h10;
    logic [1:0]  fmt_sw  = 2'h1;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, host_txd, host_rts, node_txd, host_rxd;
    logic        bus_data_in, bus_data_out, bus_data_oe, tx_pair_out;
    int          errors  = 0;
    int          n_tests = 0;

    always #20 pclk = ~pclk;
    assign bus_data_in = bus_data_oe ? bus_data_out : node_txd;

    serial_peer_model peer_u (.pclk(pclk), .host_txd(host_txd), .host_rts(host_rts), .node_txd(node_txd));

    dir_converter #(.LATE_REVISION(1'b1), .CYC_1200(SMALL_CYC), .CYC_2400(SMALL_CYC), .CYC_4800(SMALL_CYC)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rate_select_switches(rate_sw), .frame_format_switches(fmt_sw), .host_txd(host_txd),
        .host_rts(host_rts), .host_rxd(host_rxd), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
        .bus_data_oe(bus_data_oe), .tx_pair_out(tx_pair_out), .rx_pair_in(node_txd));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        cmp(32'(n), 32'h2);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Switches are scrambled after capture; the captured setting must hold.
    task automatic power_up(input logic [6:0] rs, input logic [1:0] fs);
        presetn <= 1'b0;
        rate_sw <= rs;
        fmt_sw  <= fs;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        rate_sw <= ~rs;
        fmt_sw  <= ~fs;
    endtask : power_up

    function automatic logic [31:0] status_exp(input logic [2:0] idx, input logic [1:0] f);
        return {20'h0, 4'h9 + {2'h0, f}, 1'b0, f, idx, idx == 3'h0, 1'b1};
    endfunction : status_exp

    function automatic int bit_cyc(input int i);
        case (i)
            1: return conv_pkg::BIT_CYC_115200;
            4: return conv_pkg::BIT_CYC_9600;
            5: return conv_pkg::BIT_CYC_19200;
            6: return conv_pkg::BIT_CYC_38400;
            default: return SMALL_CYC;
        endcase
    endfunction : bit_cyc

    task automatic frame_check(input int nbits, input int cyc);
        int n;
        n = 0;
        fork
            peer_u.send_frame(nbits, cyc, 10'h2A5);
            begin
                do
                begin
                    @(posedge pclk);
                    n++;
                end
                while (bus_data_oe !== 1'b1 && n < 10);
                cmp({31'h0, bus_data_out}, 32'h0);
                cmp({31'h0, host_rxd}, 32'h1);
                n = 0;
                while (bus_data_oe === 1'b1 && n < 30000)
                begin
                    n++;
                    @(posedge pclk);
                end
                cmp(32'(n), 32'(nbits * cyc));
            end
        join
    endtask : frame_check

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #4_000_000;
        errors++;
        end_of_test();
    end

    initial
    begin
        for (int i = 0; i < 7; i++)
        begin
            power_up(7'h01 << i, 2'h1);
            apb(1'b0, conv_pkg::OFS_STATUS, 32'h0);
            cmp(rd, status_exp(3'(i), 2'h1));
            if (i == 0)
            begin
                peer_u.set_lines(1'b1, 1'b1);
                repeat (4) @(posedge pclk);
                cmp({31'h0, bus_data_oe}, 32'h1);
                peer_u.set_lines(1'b0, 1'b1);
                repeat (4) @(posedge pclk);
                cmp({31'h0, bus_data_oe}, 32'h0);
            end
            else
            begin
                frame_check(10, bit_cyc(i));
                apb(1'b0, conv_pkg::OFS_FRAMES, 32'h0);
                cmp(rd, 32'h1);
            end
            $display("rate position %0d done", i);
        end
        for (int f = 0; f < 4; f++)
        begin
            power_up(7'h04, 2'(f));
            apb(1'b0, conv_pkg::OFS_STATUS, 32'h0);
            cmp(rd, status_exp(3'h2, 2'(f)));
            peer_u.set_lines(1'b0, 1'b0);
            repeat (4) @(posedge pclk);
            cmp({31'h0, host_rxd}, 32'h0);
            frame_check(9 + f, SMALL_CYC);
            $display("format %0d done", f);
        end
        apb(1'b1, conv_pkg::OFS_CTRL, 32'h1);
        apb(1'b0, conv_pkg::OFS_CTRL, 32'h0);
        cmp(rd, 32'h1);
        apb(1'b0, 12'h00C, 32'h0);
        cmp({err, rd[30:0]}, 32'h80000000);
        peer_u.set_lines(1'b0, 1'b0);
        fork
            peer_u.send_frame(10, SMALL_CYC, 10'h0FF);
            begin
                repeat (5) @(posedge pclk);
                cmp({29'h0, tx_pair_out, bus_data_oe, host_rxd}, 32'h0);
            end
        join
        $display("four-wire and address decode done");
        end_of_test();
    end
endmodule : tb_dir_converter
